// ---- aat_regs.vh ----
// register map, field positions and timing counts of the address table
// assumes a 40 MHz system clock and a plain strobe register port
// Notes on behaviour
// - permanent entries are never learned over and never removed by aging
// - recently-used flag of a permanent entry is ignored
// - fetch hashes key to an index and loads the entry registers
// - select 0 plus go stores entry registers at the hashed index
// - search go starts a walk of the whole table from location zero
// - search go clears once the walk has covered the whole table
// - search-valid flags a found valid entry in the result registers
// - reading search data result high resumes walk; invalid skipped
// - table operations run while other registers stay accessible
// - learned or looked-up dynamic entry gets its recently-used flag set
// - aging scan runs every programmed period, removing idle entries
// - aging leaves invalid and permanent entries unchanged
// - aging clears only the recently-used flag of a used dynamic entry
// - aging deletes a dynamic entry whose recently-used flag is clear
// - six multiport address and type matches forward to their vectors
// - entry holds MAC, VLAN, flags, class and nine-bit forward mask
`ifndef AAT_REGS_VH
`define AAT_REGS_VH

`define AAT_DEPTH 64
`define AAT_IDX_W 6
`define AAT_NUM_MP 6

// register offsets (byte addresses)
`define AAT_RW_CTRL 8'h00
`define AAT_KEY_MAC_LO 8'h04
`define AAT_KEY_MAC_HI 8'h08
`define AAT_KEY_VID 8'h0C
`define AAT_ENT_MAC_LO 8'h10
`define AAT_ENT_MAC_HI 8'h14
`define AAT_ENT_DATA 8'h18
`define AAT_SRCH_CTRL 8'h20
`define AAT_AGE_CTRL 8'h30
`define AAT_FAST_CTRL 8'h34
`define AAT_FAST_PORT 8'h38
`define AAT_FAST_VID 8'h3C
`define AAT_MP_CTRL 8'h44
`define AAT_SRES_MAC_LO 8'h60
`define AAT_SRES_MAC_HI 8'h64
`define AAT_SRES_DATA0 8'h74
`define AAT_SRES_DATA1 8'h78
// multiport bank: 8'h80 + 16*n, words mac low, mac high/type, vector
`define AAT_MP_BASE_BIT 7

// control fields
`define AAT_GO_BIT 0
`define AAT_RW_SEL_BIT 1
`define AAT_SRCH_VALID_BIT 1
`define AAT_FAST_ALL_BIT 31
`define AAT_AGE_CHG_BIT 31

// entry data word layout
`define AAT_VID_LSB 0
`define AAT_FWD_LSB 12
`define AAT_TC_LSB 21
`define AAT_AGE_BIT 29
`define AAT_STATIC_BIT 30
`define AAT_VALID_BIT 31

// reset values
`define AAT_AGE_TIME_RST 20'h0012C

// timing: one age-period unit of one second
`define AAT_CLK_PERIOD_NS 25
`define AAT_AGE_UNIT_NS 1000000000

`endif

// ---- aat_top.v ----
// address table with host access, sequential search, aging and multiport
// assumes synchronous frame-side requests and one-cycle register strobes
`timescale 1ns/10ps
`include "aat_regs.vh"

module aat_top #(
  parameter [31:0] AGE_UNIT_CYC = `AAT_AGE_UNIT_NS / `AAT_CLK_PERIOD_NS
) (
  // clock and reset
  input wire clock_i,
  input wire resetn_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // frame side
  input wire lookup_req_i,
  input wire learn_req_i,
  input wire [47:0] frame_mac_i,
  input wire [11:0] frame_vid_i,
  input wire [15:0] frame_etype_i,
  input wire [3:0] learn_port_i,
  output reg lookup_done_o,
  output reg lookup_hit_o,
  output reg [8:0] lookup_fwd_o,
  output reg [2:0] lookup_tc_o
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_SRCH = 5'h02;
  localparam [4:0] ST_HOLD = 5'h04;
  localparam [4:0] ST_AGE = 5'h08;
  localparam [4:0] ST_FAST = 5'h10;
  localparam [31:0] DEPTH_M1 = `AAT_DEPTH - 1;
  localparam [5:0] LAST_IDX = DEPTH_M1[5:0];

  function [5:0] aat_hash;
    input [47:0] m;
    input [11:0] v;
    aat_hash = m[5:0] ^ m[11:6] ^ m[17:12] ^ v[5:0] ^ v[11:6];
  endfunction

  // reset release
  reg rst_meta_reg;
  reg rst_sync_reg;
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rstn = rst_sync_reg;

  // table storage
  reg [47:0] tbl_mac [0:`AAT_DEPTH-1];
  reg [11:0] tbl_vid [0:`AAT_DEPTH-1];
  reg [2:0] tbl_tc [0:`AAT_DEPTH-1];
  reg [8:0] tbl_fwd [0:`AAT_DEPTH-1];
  reg [`AAT_DEPTH-1:0] tbl_valid_reg;
  reg [`AAT_DEPTH-1:0] tbl_static_reg;
  reg [`AAT_DEPTH-1:0] tbl_age_reg;

  // multiport storage
  reg [47:0] mp_mac [0:`AAT_NUM_MP-1];
  reg [15:0] mp_etype [0:`AAT_NUM_MP-1];
  reg [8:0] mp_vec [0:`AAT_NUM_MP-1];
  reg [5:0] mp_en_reg;

  // software registers
  reg rw_go_reg;
  reg rw_sel_reg;
  reg [31:0] key_mac_lo_reg;
  reg [15:0] key_mac_hi_reg;
  reg [11:0] key_vid_reg;
  reg [31:0] ent_mac_lo_reg;
  reg [15:0] ent_mac_hi_reg;
  reg [31:0] ent_data_reg;
  reg srch_go_reg;
  reg srch_valid_reg;
  reg [31:0] sres_mac_lo_reg;
  reg [15:0] sres_mac_hi_reg;
  reg [31:0] sres_data_reg;
  reg [5:0] sres_idx_reg;
  reg [19:0] age_time_reg;
  reg fast_go_reg;
  reg fast_port_all_reg;
  reg [8:0] fast_port_reg;
  reg fast_vid_all_reg;
  reg [11:0] fast_vid_reg;
  reg [4:0] state_reg;
  reg [5:0] ptr_reg;
  reg [31:0] tick_cnt_reg;
  reg [19:0] unit_cnt_reg;
  reg age_pend_reg;

  wire wr_en = reg_wr_i;
  wire mp_sel = reg_addr_i[`AAT_MP_BASE_BIT];
  wire [2:0] mp_n = reg_addr_i[6:4];
  wire [1:0] mp_w = reg_addr_i[3:2];
  wire srch_resume = reg_rd_i && (reg_addr_i == `AAT_SRES_DATA1);
  wire frame_busy = lookup_req_i | learn_req_i;
  wire [47:0] key_mac = {key_mac_hi_reg, key_mac_lo_reg};
  wire [5:0] key_idx = aat_hash(key_mac, key_vid_reg);
  wire [5:0] frm_idx = aat_hash(frame_mac_i, frame_vid_i);
  wire frm_hit = tbl_valid_reg[frm_idx] && tbl_mac[frm_idx] == frame_mac_i
    && tbl_vid[frm_idx] == frame_vid_i;
  wire ptr_last = (ptr_reg == LAST_IDX);

  // multiport compare, lowest index wins
  reg mp_hit;
  reg [8:0] mp_fwd;
  integer k;
  always @* begin
    mp_hit = 1'b0;
    mp_fwd = 9'h000;
    for (k = `AAT_NUM_MP - 1; k >= 0; k = k - 1) begin
      if (mp_en_reg[k] && mp_mac[k] == frame_mac_i &&
          mp_etype[k] == frame_etype_i) begin
        mp_hit = 1'b1;
        mp_fwd = mp_vec[k];
      end
    end
  end

  // one table write per cycle; frame traffic stalls host access and the aging walks
  reg tw_en;
  reg fl_en;
  reg [5:0] tw_idx;
  reg [47:0] tw_mac;
  reg [11:0] tw_vid;
  reg [2:0] tw_tc;
  reg [8:0] tw_fwd;
  reg [2:0] fl_val;
  reg fast_match;
  always @* begin
    tw_en = 1'b0;
    fl_en = 1'b0;
    tw_idx = ptr_reg;
    tw_mac = {ent_mac_hi_reg, ent_mac_lo_reg};
    tw_vid = ent_data_reg[`AAT_VID_LSB+11:`AAT_VID_LSB];
    tw_tc = ent_data_reg[`AAT_TC_LSB+2:`AAT_TC_LSB];
    tw_fwd = ent_data_reg[`AAT_FWD_LSB+8:`AAT_FWD_LSB];
    fl_val = {tbl_valid_reg[ptr_reg], tbl_static_reg[ptr_reg],
      tbl_age_reg[ptr_reg]};
    fast_match = (fast_port_all_reg &&
      (tbl_fwd[ptr_reg] & fast_port_reg) != 9'h000) ||
      (fast_vid_all_reg && tbl_vid[ptr_reg] == fast_vid_reg);
    if (learn_req_i) begin
      tw_idx = frm_idx;
      tw_mac = frame_mac_i;
      tw_vid = frame_vid_i;
      tw_tc = 3'h0;
      tw_fwd = 9'h001 << learn_port_i;
      fl_val = 3'b101;
      // permanent slots are not overwritten by learning
      tw_en = !(tbl_valid_reg[frm_idx] && tbl_static_reg[frm_idx]);
      fl_en = tw_en;
    end else if (lookup_req_i) begin
      tw_idx = frm_idx;
      fl_val = 3'b101;
      fl_en = frm_hit && !tbl_static_reg[frm_idx];
    end else if (state_reg == ST_IDLE && rw_go_reg && !rw_sel_reg) begin
      tw_idx = key_idx;
      fl_val = {ent_data_reg[`AAT_VALID_BIT], ent_data_reg[`AAT_STATIC_BIT],
        ent_data_reg[`AAT_AGE_BIT]};
      tw_en = 1'b1;
      fl_en = 1'b1;
    end else if (state_reg == ST_AGE) begin
      if (tbl_valid_reg[ptr_reg] && !tbl_static_reg[ptr_reg]) begin
        fl_en = 1'b1;
        if (tbl_age_reg[ptr_reg])
          fl_val = 3'b100;
        else
          fl_val = 3'b000;
      end
    end else if (state_reg == ST_FAST) begin
      if (tbl_valid_reg[ptr_reg] && !tbl_static_reg[ptr_reg] && fast_match)
      begin
        fl_en = 1'b1;
        fl_val = 3'b000;
      end
    end
  end

  always @(posedge clock_i) begin
    if (tw_en) begin
      tbl_mac[tw_idx] <= tw_mac;
      tbl_vid[tw_idx] <= tw_vid;
      tbl_tc[tw_idx] <= tw_tc;
      tbl_fwd[tw_idx] <= tw_fwd;
    end
    if (wr_en && mp_sel && mp_n < `AAT_NUM_MP) begin
      if (mp_w == 2'h0)
        mp_mac[mp_n][31:0] <= reg_wdata_i;
      if (mp_w == 2'h1) begin
        mp_mac[mp_n][47:32] <= reg_wdata_i[15:0];
        mp_etype[mp_n] <= reg_wdata_i[31:16];
      end
      if (mp_w == 2'h2)
        mp_vec[mp_n] <= reg_wdata_i[8:0];
    end
  end

  always @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      tbl_valid_reg <= {`AAT_DEPTH{1'b0}};
      tbl_static_reg <= {`AAT_DEPTH{1'b0}};
      tbl_age_reg <= {`AAT_DEPTH{1'b0}};
    end else if (fl_en) begin
      tbl_valid_reg[tw_idx] <= fl_val[2];
      tbl_static_reg[tw_idx] <= fl_val[1];
      tbl_age_reg[tw_idx] <= fl_val[0];
    end
  end

  // sequencer, registers and aging timer
  always @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      rw_go_reg <= 1'b0;
      rw_sel_reg <= 1'b0;
      key_mac_lo_reg <= 32'h00000000;
      key_mac_hi_reg <= 16'h0000;
      key_vid_reg <= 12'h000;
      ent_mac_lo_reg <= 32'h00000000;
      ent_mac_hi_reg <= 16'h0000;
      ent_data_reg <= 32'h00000000;
      srch_go_reg <= 1'b0;
      srch_valid_reg <= 1'b0;
      sres_mac_lo_reg <= 32'h00000000;
      sres_mac_hi_reg <= 16'h0000;
      sres_data_reg <= 32'h00000000;
      sres_idx_reg <= 6'h00;
      age_time_reg <= `AAT_AGE_TIME_RST;
      fast_go_reg <= 1'b0;
      fast_port_all_reg <= 1'b0;
      fast_port_reg <= 9'h000;
      fast_vid_all_reg <= 1'b0;
      fast_vid_reg <= 12'h000;
      mp_en_reg <= 6'h00;
      state_reg <= ST_IDLE;
      ptr_reg <= 6'h00;
      tick_cnt_reg <= 32'h00000000;
      unit_cnt_reg <= 20'h00000;
      age_pend_reg <= 1'b0;
      reg_rdata_o <= 32'h00000000;
      lookup_done_o <= 1'b0;
      lookup_hit_o <= 1'b0;
      lookup_fwd_o <= 9'h000;
      lookup_tc_o <= 3'h0;
    end else begin
      // frame lookup answer one cycle after request
      lookup_done_o <= lookup_req_i;
      lookup_hit_o <= lookup_req_i && (mp_hit || frm_hit);
      lookup_fwd_o <= mp_hit ? mp_fwd : (frm_hit ? tbl_fwd[frm_idx] : 9'h000);
      lookup_tc_o <= frm_hit ? tbl_tc[frm_idx] : 3'h0;

      case (state_reg)
        ST_IDLE: begin
          if (rw_go_reg) begin
            if (!frame_busy) begin
              if (rw_sel_reg) begin
                ent_mac_lo_reg <= tbl_mac[key_idx][31:0];
                ent_mac_hi_reg <= tbl_mac[key_idx][47:32];
                ent_data_reg <= {tbl_valid_reg[key_idx],
                  tbl_static_reg[key_idx], tbl_age_reg[key_idx], 5'h00,
                  tbl_tc[key_idx], tbl_fwd[key_idx], tbl_vid[key_idx]};
              end
              rw_go_reg <= 1'b0;
            end
          end else if (srch_go_reg) begin
            ptr_reg <= 6'h00;
            state_reg <= ST_SRCH;
          end else if (fast_go_reg) begin
            ptr_reg <= 6'h00;
            state_reg <= ST_FAST;
          end else if (age_pend_reg) begin
            ptr_reg <= 6'h00;
            state_reg <= ST_AGE;
          end
        end
        ST_SRCH: begin
          if (tbl_valid_reg[ptr_reg]) begin
            sres_mac_lo_reg <= tbl_mac[ptr_reg][31:0];
            sres_mac_hi_reg <= tbl_mac[ptr_reg][47:32];
            sres_data_reg <= {tbl_valid_reg[ptr_reg], tbl_static_reg[ptr_reg],
              tbl_age_reg[ptr_reg], 5'h00, tbl_tc[ptr_reg], tbl_fwd[ptr_reg],
              tbl_vid[ptr_reg]};
            sres_idx_reg <= ptr_reg;
            srch_valid_reg <= 1'b1;
            state_reg <= ST_HOLD;
          end else if (ptr_last) begin
            srch_go_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end else begin
            ptr_reg <= ptr_reg + 6'h01;
          end
        end
        ST_HOLD: begin
          if (srch_resume) begin
            srch_valid_reg <= 1'b0;
            if (ptr_last) begin
              srch_go_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end else begin
              ptr_reg <= ptr_reg + 6'h01;
              state_reg <= ST_SRCH;
            end
          end
        end
        ST_AGE, ST_FAST: begin
          if (!frame_busy) begin
            if (ptr_last) begin
              if (state_reg == ST_FAST)
                fast_go_reg <= 1'b0;
              else
                age_pend_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end else begin
              ptr_reg <= ptr_reg + 6'h01;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase

      // timer after the walk so its set beats the end-of-walk clear
      // period of zero keeps aging off
      if (tick_cnt_reg >= AGE_UNIT_CYC - 32'h1) begin
        tick_cnt_reg <= 32'h00000000;
        if (unit_cnt_reg + 20'h1 >= age_time_reg) begin
          unit_cnt_reg <= 20'h00000;
          if (age_time_reg != 20'h00000)
            age_pend_reg <= 1'b1;
        end else begin
          unit_cnt_reg <= unit_cnt_reg + 20'h1;
        end
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h1;
      end

      // software writes land last so a set beats a same-cycle clear
      if (wr_en) begin
        case (reg_addr_i)
          `AAT_RW_CTRL: begin
            rw_go_reg <= reg_wdata_i[`AAT_GO_BIT];
            rw_sel_reg <= reg_wdata_i[`AAT_RW_SEL_BIT];
          end
          `AAT_KEY_MAC_LO: key_mac_lo_reg <= reg_wdata_i;
          `AAT_KEY_MAC_HI: key_mac_hi_reg <= reg_wdata_i[15:0];
          `AAT_KEY_VID: key_vid_reg <= reg_wdata_i[11:0];
          `AAT_ENT_MAC_LO: ent_mac_lo_reg <= reg_wdata_i;
          `AAT_ENT_MAC_HI: ent_mac_hi_reg <= reg_wdata_i[15:0];
          `AAT_ENT_DATA: ent_data_reg <= reg_wdata_i & 32'hE0FFFFFF;
          `AAT_SRCH_CTRL: begin
            if (reg_wdata_i[`AAT_GO_BIT])
              srch_go_reg <= 1'b1;
          end
          `AAT_AGE_CTRL: begin
            if (reg_wdata_i[`AAT_AGE_CHG_BIT])
              age_time_reg <= reg_wdata_i[19:0];
          end
          `AAT_FAST_CTRL: begin
            if (reg_wdata_i[`AAT_GO_BIT])
              fast_go_reg <= 1'b1;
          end
          `AAT_FAST_PORT: begin
            fast_port_all_reg <= reg_wdata_i[`AAT_FAST_ALL_BIT];
            fast_port_reg <= reg_wdata_i[8:0];
          end
          `AAT_FAST_VID: begin
            fast_vid_all_reg <= reg_wdata_i[`AAT_FAST_ALL_BIT];
            fast_vid_reg <= reg_wdata_i[11:0];
          end
          `AAT_MP_CTRL: mp_en_reg <= reg_wdata_i[5:0];
          default: ;
        endcase
      end

      if (reg_rd_i) begin
        case (reg_addr_i)
          `AAT_RW_CTRL: reg_rdata_o <= {30'h0, rw_sel_reg, rw_go_reg};
          `AAT_KEY_MAC_LO: reg_rdata_o <= key_mac_lo_reg;
          `AAT_KEY_MAC_HI: reg_rdata_o <= {16'h0000, key_mac_hi_reg};
          `AAT_KEY_VID: reg_rdata_o <= {20'h00000, key_vid_reg};
          `AAT_ENT_MAC_LO: reg_rdata_o <= ent_mac_lo_reg;
          `AAT_ENT_MAC_HI: reg_rdata_o <= {16'h0000, ent_mac_hi_reg};
          `AAT_ENT_DATA: reg_rdata_o <= ent_data_reg;
          `AAT_SRCH_CTRL: reg_rdata_o <= {30'h0, srch_valid_reg, srch_go_reg};
          `AAT_AGE_CTRL: reg_rdata_o <= {12'h000, age_time_reg};
          `AAT_FAST_CTRL: reg_rdata_o <= {31'h0, fast_go_reg};
          `AAT_FAST_PORT: reg_rdata_o <= {fast_port_all_reg, 22'h0,
            fast_port_reg};
          `AAT_FAST_VID: reg_rdata_o <= {fast_vid_all_reg, 19'h0,
            fast_vid_reg};
          `AAT_MP_CTRL: reg_rdata_o <= {26'h0, mp_en_reg};
          `AAT_SRES_MAC_LO: reg_rdata_o <= sres_mac_lo_reg;
          `AAT_SRES_MAC_HI: reg_rdata_o <= {16'h0000, sres_mac_hi_reg};
          `AAT_SRES_DATA0: reg_rdata_o <= sres_data_reg;
          `AAT_SRES_DATA1: reg_rdata_o <= {26'h0, sres_idx_reg};
          default: begin
            if (mp_sel && mp_n < `AAT_NUM_MP && mp_w == 2'h0)
              reg_rdata_o <= mp_mac[mp_n][31:0];
            else if (mp_sel && mp_n < `AAT_NUM_MP && mp_w == 2'h1)
              reg_rdata_o <= {mp_etype[mp_n], mp_mac[mp_n][47:32]};
            else if (mp_sel && mp_n < `AAT_NUM_MP && mp_w == 2'h2)
              reg_rdata_o <= {23'h0, mp_vec[mp_n]};
            else
              reg_rdata_o <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule // aat_top

// ---- aat_chk.sv ----
// port assertions for the address table block
// assumes one clock and a master that never raises both strobes at once
`timescale 1ns/10ps
`include "aat_regs.vh"
module aat_chk (
  // clock and reset
  input wire clock_i,
  input wire resetn_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_rdata_o,
  // frame side
  input wire lookup_req_i,
  input wire learn_req_i,
  input wire [47:0] frame_mac_i,
  input wire [11:0] frame_vid_i,
  input wire [15:0] frame_etype_i,
  input wire [3:0] learn_port_i,
  input wire lookup_done_o,
  input wire lookup_hit_o,
  input wire [8:0] lookup_fwd_o,
  input wire [2:0] lookup_tc_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  wire rd_hole = reg_rd_i && (reg_addr_i == 8'h1C || reg_addr_i >= 8'hE0);
  wire rd_data = reg_rd_i && (reg_addr_i == `AAT_ENT_DATA ||
                              reg_addr_i == `AAT_SRES_DATA0);
  a_done_follows_req: assert property (lookup_req_i |=> lookup_done_o)
    else $error("lookup done missing");
  a_done_needs_req: assert property (!lookup_req_i |=> !lookup_done_o)
    else $error("lookup done without request");
  a_miss_is_empty: assert property (lookup_done_o && !lookup_hit_o |->
    lookup_fwd_o == 9'h000 && lookup_tc_o == 3'h0)
    else $error("miss carries a port map");
  a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  a_hole_reads_zero: assert property (rd_hole |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_srch_spare_zero: assert property (reg_rd_i &&
    reg_addr_i == `AAT_SRCH_CTRL |=> reg_rdata_o[31:2] == 30'h0)
    else $error("search control spare bits set");
  a_data_spare_zero: assert property (rd_data |=>
    reg_rdata_o[28:24] == 5'h00)
    else $error("entry data spare bits set");
  a_index_width: assert property (reg_rd_i &&
    reg_addr_i == `AAT_SRES_DATA1 |=> reg_rdata_o[31:6] == 26'h0)
    else $error("search index too wide");
  a_key_readback: assert property (reg_wr_i &&
    reg_addr_i == `AAT_KEY_MAC_LO ##1 !reg_wr_i ##1 reg_rd_i &&
    reg_addr_i == `AAT_KEY_MAC_LO |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("key register readback wrong");
  a_vector_readback: assert property (reg_wr_i &&
    reg_addr_i == 8'h88 ##1 !reg_wr_i ##1 reg_rd_i && reg_addr_i == 8'h88
    |=> reg_rdata_o[8:0] == $past(reg_wdata_i[8:0], 3))
    else $error("multiport vector readback wrong");
  c_lookup_hit: cover property (lookup_done_o && lookup_hit_o);
  c_search_resume: cover property (reg_rd_i && reg_addr_i == `AAT_SRES_DATA1);
  c_learn: cover property (learn_req_i);
endmodule // aat_chk

// ---- aat_host.sv ----
// host model working the table through the strobe register port
// assumes read data stand in the cycle after the read strobe and hold until the next read
`timescale 1ns/10ps
`include "aat_regs.vh"
module aat_host (
  // clock
  input wire clock_i,
  // register port
  output reg [7:0] addr_o,
  output reg [31:0] wdata_o,
  output reg wr_o,
  output reg rd_o,
  input wire [31:0] rdata_i
);
  reg ok;
  initial begin
    addr_o = 8'h00;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    ok = 1'b0;
  end
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clock_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clock_i);
      wr_o <= 1'b0;
      wdata_o <= ~d; // stale data would hide a missed strobe
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    begin
      @(posedge clock_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clock_i);
      rd_o <= 1'b0;
      #1 d = rdata_i;
    end
  endtask
  task poll(input [7:0] a);
    integer k;
    reg [31:0] q;
    begin
      k = 0;
      q = 32'h1;
      while (q[0] && k < 400) begin
        rd(a, q);
        k = k + 1;
      end
      ok = !q[0];
    end
  endtask
  task run(input sel);
    begin
      wr(`AAT_RW_CTRL, {30'h0, sel, 1'b0});
      wr(`AAT_RW_CTRL, {30'h0, sel, 1'b1});
      poll(`AAT_RW_CTRL);
    end
  endtask
  task fetch(input [47:0] m, input [11:0] v);
    begin
      wr(`AAT_KEY_MAC_LO, m[31:0]);
      wr(`AAT_KEY_MAC_HI, {16'h0000, m[47:32]});
      wr(`AAT_KEY_VID, {20'h00000, v});
      run(1'b1);
    end
  endtask
endmodule // aat_host

// ---- test_address_table_access_aging.sv ----
// self-checking bench for the address table block
// assumes a shortened age unit of four clock cycles
`timescale 1ns/10ps
`include "aat_regs.vh"
module test_address_table_access_aging;
  reg clock_i = 1'b0;
  reg resetn_i = 1'b0;
  reg lookup_req_i = 1'b0;
  reg learn_req_i = 1'b0;
  reg [47:0] frame_mac_i = 48'h0;
  reg [11:0] frame_vid_i = 12'h000;
  reg [15:0] frame_etype_i = 16'h0000;
  reg [3:0] learn_port_i = 4'h0;
  wire [7:0] reg_addr_i;
  wire [31:0] reg_wdata_i;
  wire reg_wr_i;
  wire reg_rd_i;
  wire [31:0] reg_rdata_o;
  wire lookup_done_o;
  wire lookup_hit_o;
  wire [8:0] lookup_fwd_o;
  wire [2:0] lookup_tc_o;
  integer errors = 0;
  integer checks = 0;
  integer cyc = 0;
  integer i, n, k;
  reg [31:0] lfsr = 32'h3C1DBC81;
  reg [31:0] d, d2, vec;
  reg [47:0] km [0:1];
  reg [31:0] ed [0:1];
  reg [47:0] kd, mm;
  reg [13:0] r;
  reg [7:0] base;
  always #12.5 clock_i = ~clock_i;
  aat_top #(.AGE_UNIT_CYC(32'h4)) DUT (.clock_i(clock_i),
    .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .lookup_req_i(lookup_req_i), .learn_req_i(learn_req_i),
    .frame_mac_i(frame_mac_i), .frame_vid_i(frame_vid_i),
    .frame_etype_i(frame_etype_i), .learn_port_i(learn_port_i),
    .lookup_done_o(lookup_done_o), .lookup_hit_o(lookup_hit_o),
    .lookup_fwd_o(lookup_fwd_o), .lookup_tc_o(lookup_tc_o));
  aat_host H (.clock_i(clock_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
    .wr_o(reg_wr_i), .rd_o(reg_rd_i), .rdata_i(reg_rdata_o));
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task conclude;
    begin
      if (errors == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task frame(input lk, input [47:0] m, input [11:0] v, input [15:0] t,
             input [3:0] p);
    begin
      @(posedge clock_i);
      lookup_req_i <= lk;
      learn_req_i <= !lk;
      frame_mac_i <= m;
      frame_vid_i <= v;
      frame_etype_i <= t;
      learn_port_i <= p;
      @(posedge clock_i);
      lookup_req_i <= 1'b0;
      learn_req_i <= 1'b0;
      frame_mac_i <= ~m;
      #1 r = {lookup_done_o, lookup_hit_o, lookup_fwd_o, lookup_tc_o};
    end
  endtask
  task get(input [47:0] m, input [11:0] v, output [31:0] e);
    begin
      H.fetch(m, v);
      chk({31'h0, H.ok}, 32'h1);
      H.rd(`AAT_ENT_DATA, e);
    end
  endtask
  always @(posedge clock_i) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      errors = errors + 1;
      conclude;
    end
  end
  initial begin
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    H.rd(`AAT_AGE_CTRL, d);
    chk({12'h000, d[19:0]}, {12'h000, `AAT_AGE_TIME_RST});
    H.wr(`AAT_AGE_CTRL, 32'h0000_0001);
    H.rd(`AAT_AGE_CTRL, d);
    chk({12'h000, d[19:0]}, {12'h000, `AAT_AGE_TIME_RST});
    H.rd(8'h1C, d);
    chk(d, 32'h0);
    H.wr(`AAT_AGE_CTRL, 32'h8000_0000);
    H.wr(`AAT_KEY_MAC_LO, lfsr);
    H.rd(`AAT_KEY_MAC_LO, d);
    chk(d, lfsr);
    for (i = 0; i < 2; i = i + 1) begin
      lfsr = nxt(lfsr);
      km[i] = {lfsr[29:0], 12'h000, (i == 0) ? 6'h05 : 6'h2A};
      get(km[i], 12'h000, d);
      chk({31'h0, d[31]}, 32'h0);
      H.wr(`AAT_ENT_MAC_LO, km[i][31:0]);
      H.wr(`AAT_ENT_MAC_HI, {16'h0000, km[i][47:32]});
      ed[i] = {2'b11, i[0], 5'h00, lfsr[10:8], lfsr[20:12], 12'h000};
      H.wr(`AAT_ENT_DATA, ed[i]);
      H.run(1'b0);
      frame(1'b0, km[i], 12'h000, 16'h0000, 4'h2);
      frame(1'b1, km[i], 12'h000, 16'h0000, 4'h0);
      chk({18'h0, r}, {18'h0, 2'b11, ed[i][20:12], ed[i][23:21]});
      get(km[i], 12'h000, d);
      chk(d, ed[i]);
    end
    lfsr = nxt(lfsr);
    kd = {lfsr[29:0], 12'h000, 6'h11};
    frame(1'b0, kd, 12'h000, 16'h0000, 4'h3);
    get(kd, 12'h000, d);
    chk(d, 32'hA000_8000);
    H.rd(`AAT_ENT_MAC_LO, d);
    chk(d, kd[31:0]);
    H.wr(`AAT_AGE_CTRL, 32'h8000_0014);
    for (k = 0; k < 20; k = k + 1) begin
      repeat (15) @(posedge clock_i);
      frame(1'b1, kd, 12'h000, 16'h0000, 4'h0);
      chk({30'h0, r[13:12]}, 32'h3);
    end
    repeat (400) @(posedge clock_i);
    get(kd, 12'h000, d);
    chk({31'h0, d[31]}, 32'h0);
    for (i = 0; i < 2; i = i + 1) begin
      get(km[i], 12'h000, d);
      chk(d, ed[i]);
    end
    H.wr(`AAT_AGE_CTRL, 32'h8000_0000);
    H.wr(`AAT_SRCH_CTRL, 32'h1);
    n = 0;
    for (i = 0; i < 3; i = i + 1) begin
      k = 0;
      d = 32'h1;
      while (d[1:0] == 2'b01 && k < 200) begin
        H.rd(`AAT_SRCH_CTRL, d);
        k = k + 1;
      end
      if (d[1] && n < 2) begin
        H.rd(`AAT_SRES_MAC_LO, d2);
        chk(d2, km[n][31:0]);
        H.rd(`AAT_SRES_DATA0, d2);
        chk(d2, ed[n]);
        H.rd(`AAT_SRES_DATA1, d2);
        chk(d2, (n == 0) ? 32'h05 : 32'h2A);
        n = n + 1;
      end
    end
    chk(n, 32'h2);
    chk(d, 32'h0);
    for (i = 0; i < 2; i = i + 1) begin
      frame(1'b0, kd, i ? 12'h00A : 12'h000, 16'h0000, 4'h6);
      H.wr(`AAT_FAST_PORT, i ? 32'h0 : 32'h8000_0040);
      H.wr(`AAT_FAST_VID, i ? 32'h8000_000A : 32'h0);
      H.wr(`AAT_FAST_CTRL, 32'h1);
      H.poll(`AAT_FAST_CTRL);
      chk({31'h0, H.ok}, 32'h1);
      get(kd, i ? 12'h00A : 12'h000, d);
      chk({31'h0, d[31]}, 32'h0);
      get(km[0], 12'h000, d);
      chk(d, ed[0]);
    end
    for (i = 0; i < 6; i = i + 1) begin
      lfsr = nxt(lfsr);
      mm = {lfsr[15:0], lfsr};
      vec = {23'h0, lfsr[8:0]};
      base = 8'h80 + 8'h10 * i[7:0];
      H.wr(base, mm[31:0]);
      H.wr(base + 8'h04, {lfsr[31:16], mm[47:32]});
      H.wr(base + 8'h08, vec);
      H.rd(base + 8'h08, d2);
      chk(d2, vec);
      H.wr(`AAT_MP_CTRL, 32'h0);
      frame(1'b1, mm, 12'h000, lfsr[31:16], 4'h0);
      chk({18'h0, r}, {18'h0, 14'h2000});
      H.wr(`AAT_MP_CTRL, 32'h1 << i);
      frame(1'b1, mm, 12'h000, lfsr[31:16], 4'h0);
      chk({18'h0, r}, {18'h0, 2'b11, vec[8:0], 3'h0});
      frame(1'b1, mm, 12'h000, ~lfsr[31:16], 4'h0);
      chk({18'h0, r}, {18'h0, 14'h2000});
    end
    conclude;
  end
endmodule // test_address_table_access_aging
bind aat_top aat_chk CHK (.clock_i(clock_i), .resetn_i(resetn_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .lookup_req_i(lookup_req_i), .learn_req_i(learn_req_i),
  .frame_mac_i(frame_mac_i), .frame_vid_i(frame_vid_i),
  .frame_etype_i(frame_etype_i), .learn_port_i(learn_port_i),
  .lookup_done_o(lookup_done_o), .lookup_hit_o(lookup_hit_o),
  .lookup_fwd_o(lookup_fwd_o), .lookup_tc_o(lookup_tc_o));
